/* File: hw/mac_top.sv */
// monitor alarm control: configuration registers, alarm qualification, flags, alarm pin
// assumes an APB master on the system clock and same-clock sample and range inputs
//
// Functional notes
// [RULE1] rate field bits 9-8 picks sample rate
// [RULE2] voltage alarm after 1..256 consecutive bad samples
// [RULE3] temperature alarm after 1..8 consecutive bad samples
// [RULE4] one good sample restarts the run count
// [RULE5] bit 14 gates input zero alarm
// [RULE6] flags always set; pin only when enabled
// [RULE7] bit 13 gates input one alarm
// [RULE8] bit 12 gates input two alarm
// [RULE9] bit 11 gates input three alarm
// [RULE10] bit 10 gates local temperature low alarm
// [RULE11] bit 9 gates local temperature high alarm
// [RULE12] bit 8 gates remote one low alarm
// [RULE13] converter config resets 0070h, upper bits zero
// [RULE14] alarm control resets 0000h, reserved bits zero
// [RULE15] bits 7-3 gate remote high, low, fault alarms
// [RULE16] bit 2 selects held or live flags
// [RULE17] alarm pin needs output enable bit 9
// [RULE18] global flag ORs flags, clears on status read
// [RULE19] reserved writes ignored; new count from next sample
`timescale 1ns/1ps
module mac_top
   import mac_pkg::*;
(
   input  wire logic                     i_ref_clk,
   input  wire logic                     i_rst_n,
   input  wire logic                     i_clk_en,
   // apb slave
   input  wire logic                     i_psel,
   input  wire logic                     i_penable,
   input  wire logic                     i_pwrite,
   input  wire logic [mac_pkg::ADDR_W-1:0] i_paddr,
   input  wire logic [mac_pkg::DATA_W-1:0] i_pwdata,
   output logic      [mac_pkg::DATA_W-1:0] o_prdata,
   output logic                          o_pready,
   output logic                          o_pslverr,
   // per-source samples, ordered as the enable bits 3..14
   input  wire logic [mac_pkg::NUM_SRC-1:0] i_sample_valid,
   input  wire logic [mac_pkg::NUM_SRC-1:0] i_out_of_range,
   // converter and alarm side
   output logic      [1:0]               o_sample_rate_select,
   output logic                          o_sample_tick,
   output logic                          o_alarm_n,
   output logic                          o_irq
);
   import mac_pkg::*;

   // =========================================================
   // declarations
   // =========================================================
   logic [REG_W-1:0]      conv_cfg_reg;
   logic [REG_W-1:0]      alarm_enable_control_reg;
   logic [REG_W-1:0]      out_cfg_reg;
   logic [REG_W-1:0]      flag_reg;
   logic [REG_W-1:0]      flag_next;
   logic [REG_W-1:0]      irq_stat_reg;
   logic [REG_W-1:0]      irq_stat_next;
   logic [REG_W-1:0]      irq_mask_reg;
   logic                  global_reg;
   logic [NUM_SRC-1:0]    src_active;
   logic [CNT_W-1:0]      volt_target;
   logic [CNT_W-1:0]      temp_target;
   logic [2:0]            volt_code;
   logic [1:0]            temp_code;
   logic [RATE_CNT_W-1:0] rate_cnt_reg;
   logic [RATE_CNT_W-1:0] rate_period_m1;
   logic                  apb_access;
   logic                  apb_write;
   logic                  apb_read;
   logic                  status_read;
   logic [REG_W-1:0]      wdata16;
   logic [REG_W-1:0]      rdata_next;
   logic                  addr_hit;

   // =========================================================
   // apb handshake
   // =========================================================
   // one wait state: pready rises in the second access cycle, the transfer
   // completes at the edge where pready is seen high
   assign apb_access  = i_psel && i_penable && o_pready;
   assign apb_write   = apb_access && i_pwrite;
   assign apb_read    = apb_access && !i_pwrite;
   assign status_read = apb_read && (i_paddr == ADDR_STATUS);
   assign wdata16     = i_pwdata[REG_W-1:0];

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pready <= 1'b0;
      end else if (i_clk_en) begin
         o_pready <= i_psel && i_penable && !o_pready;
      end
   end

   // =========================================================
   // read decode
   // =========================================================
   always_comb begin
      rdata_next = '0;
      addr_hit   = 1'b1;
      if (i_paddr == ADDR_CONV_CFG) begin
         rdata_next = conv_cfg_reg;
      end else if (i_paddr == ADDR_ALARM_ENABLE_CONTROL) begin
         rdata_next = alarm_enable_control_reg;
      end else if (i_paddr == ADDR_OUT_CFG) begin
         rdata_next = out_cfg_reg;
         rdata_next[GLOBAL_FLAG_BIT] = global_reg;
      end else if (i_paddr == ADDR_STATUS) begin
         rdata_next = flag_reg & SRC_MASK;
      end else if (i_paddr == ADDR_IRQ_STAT) begin
         rdata_next = irq_stat_reg;
      end else if (i_paddr == ADDR_IRQ_MASK) begin
         rdata_next = irq_mask_reg;
      end else begin
         addr_hit   = 1'b0;
      end
   end

   // read data and error are loaded together with pready
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_prdata  <= '0;
         o_pslverr <= 1'b0;
      end else if (i_clk_en) begin
         if (i_psel && i_penable && !o_pready) begin
            o_prdata  <= {{(DATA_W-REG_W){1'b0}}, rdata_next};
            o_pslverr <= !addr_hit;
         end else begin
            o_pslverr <= 1'b0;
         end
      end
   end

   // =========================================================
   // configuration registers
   // =========================================================
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         conv_cfg_reg <= CONV_CFG_RESET;                                // [RULE13]
      end else if (i_clk_en && apb_write && i_paddr == ADDR_CONV_CFG) begin
         conv_cfg_reg <= wdata16 & CONV_CFG_WMASK;                      // [RULE13] [RULE19]
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         alarm_enable_control_reg <= ALARM_ENABLE_CONTROL_RESET;                                // [RULE14]
      end else if (i_clk_en && apb_write && i_paddr == ADDR_ALARM_ENABLE_CONTROL) begin
         alarm_enable_control_reg <= wdata16 & ALARM_ENABLE_CONTROL_WMASK;                      // [RULE14] [RULE19]
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         out_cfg_reg <= OUT_CFG_RESET;
      end else if (i_clk_en && apb_write && i_paddr == ADDR_OUT_CFG) begin
         out_cfg_reg <= wdata16 & OUT_CFG_WMASK;                        // [RULE19]
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_mask_reg <= '0;
      end else if (i_clk_en && apb_write && i_paddr == ADDR_IRQ_MASK) begin
         irq_mask_reg <= wdata16 & SRC_MASK;
      end
   end

   // =========================================================
   // sample rate
   // =========================================================
   // each code step halves the rate: 500, 250, 125, 62.5 kSPS
   assign rate_period_m1 = (BASE_PERIOD_CYC << conv_cfg_reg[RATE_LSB +: 2])
                           - RATE_CNT_W'(1);                            // [RULE1]

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rate_cnt_reg  <= '0;
         o_sample_tick <= 1'b0;
      end else if (i_clk_en) begin
         if (rate_cnt_reg >= rate_period_m1) begin                      // [RULE1]
            rate_cnt_reg  <= '0;
            o_sample_tick <= 1'b1;
         end else begin
            rate_cnt_reg  <= rate_cnt_reg + RATE_CNT_W'(1);
            o_sample_tick <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_sample_rate_select <= CONV_CFG_RESET[RATE_LSB +: 2];
      end else if (i_clk_en) begin
         o_sample_rate_select <= conv_cfg_reg[RATE_LSB +: 2];           // [RULE1]
      end
   end

   // =========================================================
   // filter counts
   // =========================================================
   assign volt_code = conv_cfg_reg[VFILT_LSB +: 3];
   assign temp_code = conv_cfg_reg[TFILT_LSB +: 2];

   // voltage: 1, 4, 8, 16, 32, 64, 128, 256
   assign volt_target = (volt_code == 3'h0) ? CNT_W'(1)
                        : (CNT_W'(1) << ({1'b0, volt_code} + 4'h1));    // [RULE2]
   // temperature: 1, 2, 4, 8
   assign temp_target = CNT_W'(1) << temp_code;                         // [RULE3]

   // =========================================================
   // per-source qualification and flags
   // =========================================================
   assign flag_next[SRC_LSB-1:0]       = '0;
   assign flag_next[REG_W-1]           = 1'b0;

   generate
      for (genvar j = 0; j < NUM_SRC; j++) begin : g_src
         mac_qualify u_qual (
            .i_ref_clk      (i_ref_clk),
            .i_rst_n        (i_rst_n),
            .i_clk_en       (i_clk_en),
            .i_sample       (i_sample_valid[j]),
            .i_out_of_range (i_out_of_range[j]),
            .i_target       ((j >= FIRST_VOLT_SRC) ? volt_target : temp_target),
            .o_active       (src_active[j])
         );

         // live mode follows the condition; held mode clears only on a status
         // read after the condition has gone, and a new condition wins
         assign flag_next[j+SRC_LSB] =
            alarm_enable_control_reg[LATCH_DIS_BIT] ? src_active[j]                 // [RULE16]
            : (src_active[j] || (flag_reg[j+SRC_LSB] && !status_read)); // [RULE6] [RULE16]
      end
   endgenerate

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flag_reg <= '0;
      end else if (i_clk_en) begin
         flag_reg <= flag_next;                                         // [RULE6]
      end
   end

   // =========================================================
   // global alarm flag
   // =========================================================
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         global_reg <= 1'b0;
      end else if (i_clk_en) begin
         if (|(flag_next & SRC_MASK)) begin                             // [RULE18]
            global_reg <= 1'b1;
         end else if (status_read) begin
            global_reg <= 1'b0;                                         // [RULE18]
         end
      end
   end

   // =========================================================
   // alarm pin
   // =========================================================
   // bit positions of flags and enables coincide, so one or-reduce covers
   // inputs zero to three (14..11), local temp (10, 9), remote (8..3)
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_alarm_n <= 1'b1;
      end else if (i_clk_en) begin
         o_alarm_n <= !(out_cfg_reg[ALARM_OUT_EN_BIT]                   // [RULE17]
                        && |(flag_next & alarm_enable_control_reg & SRC_MASK));     // [RULE5] [RULE6] [RULE7] [RULE8] [RULE9] [RULE10] [RULE11] [RULE12] [RULE15]
      end
   end

   // =========================================================
   // interrupt status, write one to clear, set wins
   // =========================================================
   always_comb begin
      irq_stat_next = irq_stat_reg;
      if (apb_write && i_paddr == ADDR_IRQ_STAT) begin
         irq_stat_next = irq_stat_reg & ~wdata16;
      end
      irq_stat_next = (irq_stat_next | (flag_next & ~flag_reg)) & SRC_MASK;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_stat_reg <= '0;
         o_irq        <= 1'b0;
      end else if (i_clk_en) begin
         irq_stat_reg <= irq_stat_next;
         o_irq        <= |(irq_stat_next & irq_mask_reg);
      end
   end

endmodule

/* File: hw/mac_pkg.sv */
// monitor alarm control: shared constants, register map and field layout
// assumes a 100 MHz system clock and an APB slave with 32-bit data
package mac_pkg;

   // =========================================================
   // clock and converter timing
   // =========================================================
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned BASE_RATE_SPS   = 500_000;
   localparam int unsigned RATE_CNT_W      = 11;
   // cycles between samples at the fastest rate, code 00
   localparam logic [RATE_CNT_W-1:0] BASE_PERIOD_CYC = RATE_CNT_W'(CLK_HZ / BASE_RATE_SPS);

   // =========================================================
   // bus geometry
   // =========================================================
   localparam int unsigned ADDR_W  = 12;
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned REG_W   = 16;

   // register indexes; byte address is four times the index
   localparam logic [7:0] IDX_OUT_CFG  = 8'h4c;
   localparam logic [7:0] IDX_CONV_CFG = 8'h4d;
   localparam logic [7:0] IDX_ALARM_ENABLE_CONTROL = 8'h4e;
   localparam logic [7:0] IDX_STATUS   = 8'h4f;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h50;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h51;

   localparam logic [ADDR_W-1:0] ADDR_OUT_CFG  = {2'b00, IDX_OUT_CFG, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_CONV_CFG = {2'b00, IDX_CONV_CFG, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_ALARM_ENABLE_CONTROL = {2'b00, IDX_ALARM_ENABLE_CONTROL, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_STATUS   = {2'b00, IDX_STATUS, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = {2'b00, IDX_IRQ_STAT, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {2'b00, IDX_IRQ_MASK, 2'b00};

   // =========================================================
   // reset values and writable bits
   // =========================================================
   localparam logic [REG_W-1:0] CONV_CFG_RESET = 16'h0070;
   localparam logic [REG_W-1:0] CONV_CFG_WMASK = 16'h03f8;
   localparam logic [REG_W-1:0] ALARM_ENABLE_CONTROL_RESET = 16'h0000;
   localparam logic [REG_W-1:0] ALARM_ENABLE_CONTROL_WMASK = 16'h7ffc;
   localparam logic [REG_W-1:0] OUT_CFG_RESET  = 16'h0000;
   localparam logic [REG_W-1:0] OUT_CFG_WMASK  = 16'h0200;
   localparam logic [REG_W-1:0] SRC_MASK       = 16'h7ff8;

   // =========================================================
   // field positions
   // =========================================================
   localparam int unsigned RATE_LSB          = 8;
   localparam int unsigned VFILT_LSB         = 5;
   localparam int unsigned TFILT_LSB         = 3;
   localparam int unsigned LATCH_DIS_BIT     = 2;
   localparam int unsigned ALARM_OUT_EN_BIT  = 9;
   localparam int unsigned GLOBAL_FLAG_BIT   = 6;
   localparam int unsigned SRC_LSB           = 3;
   localparam int unsigned NUM_SRC           = 12;
   // sources at or above this index are the four voltage inputs
   localparam int unsigned FIRST_VOLT_SRC    = 8;
   localparam int unsigned CNT_W             = 9;

endpackage

/* File: hw/mac_qualify.sv */
// monitor alarm control: consecutive out-of-range run counter for one source
// assumes sample strobes and range results come from logic on the same clock
`timescale 1ns/1ps
module mac_qualify
   import mac_pkg::*;
(
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_clk_en,
   input  wire logic             i_sample,
   input  wire logic             i_out_of_range,
   input  wire logic [CNT_W-1:0] i_target,
   output logic                  o_active
);
   import mac_pkg::*;

   logic [CNT_W-1:0] run_reg;
   logic [CNT_W:0]   run_plus;

   assign run_plus = {1'b0, run_reg} + (CNT_W+1)'(1);

   // =========================================================
   // run counter and qualified condition
   // =========================================================
   // target read on each strobe: a new count applies from the next sample
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         run_reg  <= '0;
         o_active <= 1'b0;
      end else if (i_clk_en && i_sample) begin
         if (i_out_of_range) begin
            if (run_plus >= {1'b0, i_target}) begin                  // [RULE2] [RULE3] [RULE19]
               run_reg  <= i_target;
               o_active <= 1'b1;
            end else begin
               run_reg  <= run_plus[CNT_W-1:0];
            end
         end else begin
            run_reg  <= '0;                                           // [RULE4]
            o_active <= 1'b0;
         end
      end
   end

endmodule

/* File: tb/mac_checker.sv */
// monitor alarm control: port-level checker, bound into mac_top
// assumes one clock domain and one apb wait state
`timescale 1ns/1ps
module mac_checker
   import mac_pkg::*;
(
   input  wire logic                        i_ref_clk,
   input  wire logic                        i_rst_n,
   input  wire logic                        i_clk_en,
   input  wire logic                        i_psel,
   input  wire logic                        i_penable,
   input  wire logic                        i_pwrite,
   input  wire logic [mac_pkg::ADDR_W-1:0]  i_paddr,
   input  wire logic [mac_pkg::DATA_W-1:0]  o_prdata,
   input  wire logic                        o_pready,
   input  wire logic                        o_pslverr,
   input  wire logic [mac_pkg::NUM_SRC-1:0] i_sample_valid,
   input  wire logic [mac_pkg::NUM_SRC-1:0] i_out_of_range,
   input  wire logic [1:0]                  o_sample_rate_select,
   input  wire logic                        o_sample_tick,
   input  wire logic                        o_alarm_n
);
   import mac_pkg::*;
   logic        mapped;
   logic        bad_smp;
   logic        wr_done;
   logic [11:0] gap;
   logic        seen;
   assign mapped  = i_paddr inside {ADDR_OUT_CFG, ADDR_CONV_CFG, ADDR_ALARM_ENABLE_CONTROL,
                                    ADDR_STATUS, ADDR_IRQ_STAT, ADDR_IRQ_MASK};
   assign bad_smp = |(i_sample_valid & i_out_of_range);
   assign wr_done = o_pready && i_psel && i_penable && i_pwrite;
   // =========================================================
   // tick spacing tracker
   // =========================================================
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         gap  <= '0;
         seen <= 1'b0;
      end else if (i_clk_en) begin
         gap  <= o_sample_tick ? 12'h1 : gap + 12'h1;
         seen <= seen | o_sample_tick;
      end
   end
   // =========================================================
   // properties
   // =========================================================
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_setup;  i_psel && !i_penable; endsequence
   sequence s_access; i_psel && i_penable;  endsequence
   property p_pready_wait;   s_setup ##1 s_access |=> o_pready; endproperty
   property p_pready_access; o_pready |-> i_psel && i_penable; endproperty
   property p_pready_pulse;  o_pready |=> !o_pready; endproperty
   property p_slverr_set;    o_pready && !mapped |-> o_pslverr; endproperty
   property p_slverr_only;   o_pslverr |-> o_pready && !mapped; endproperty
   property p_prdata_hi;     o_pready |-> o_prdata[31:16] == 16'h0000; endproperty
   property p_tick_pulse;    o_sample_tick |=> !o_sample_tick; endproperty
   property p_tick_period;
      o_sample_tick && seen && !$past(wr_done, 2)
         |-> gap == (12'(BASE_PERIOD_CYC) << o_sample_rate_select);
   endproperty
   property p_rate_cause;
      !$stable(o_sample_rate_select)
         |-> $past(wr_done && i_paddr == ADDR_CONV_CFG, 2);
   endproperty
   property p_alarm_cause;
      $fell(o_alarm_n) |-> $past(bad_smp, 2) || $past(wr_done) || $past(wr_done, 2);
   endproperty
   a_pready_wait:   assert property (p_pready_wait)   else $error("pready late");
   a_pready_access: assert property (p_pready_access) else $error("pready outside access");
   a_pready_pulse:  assert property (p_pready_pulse)  else $error("pready too long");
   a_slverr_set:    assert property (p_slverr_set)    else $error("no slverr");
   a_slverr_only:   assert property (p_slverr_only)   else $error("stray slverr");
   a_prdata_hi:     assert property (p_prdata_hi)     else $error("prdata upper set");
   a_tick_pulse:    assert property (p_tick_pulse)    else $error("tick too long");
   a_tick_period:   assert property (p_tick_period)   else $error("tick period");
   a_rate_cause:    assert property (p_rate_cause)    else $error("rate moved");
   a_alarm_cause:   assert property (p_alarm_cause)   else $error("alarm fell");
endmodule

bind mac_top mac_checker i_mac_checker (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
   .i_clk_en(i_clk_en), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
   .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
   .o_pslverr(o_pslverr), .i_sample_valid(i_sample_valid), .i_out_of_range(i_out_of_range),
   .o_sample_rate_select(o_sample_rate_select), .o_sample_tick(o_sample_tick),
   .o_alarm_n(o_alarm_n));

/* File: tb/tb.sv */
// monitor alarm control: self-checking bench driving apb and sample ports
// assumes the clock enable stays high throughout
`timescale 1ns/1ps
module tb;
   import mac_pkg::*;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0]       wdata;
      logic [31:0]       rdata;
      logic              err;
   } mac_row_t;
   logic                i_ref_clk;
   logic                i_rst_n;
   logic                i_psel;
   logic                i_penable;
   logic                i_pwrite;
   logic [ADDR_W-1:0]   i_paddr;
   logic [DATA_W-1:0]   i_pwdata;
   logic [DATA_W-1:0]   o_prdata;
   logic                o_pready;
   logic                o_pslverr;
   logic [NUM_SRC-1:0]  i_sample_valid;
   logic [NUM_SRC-1:0]  i_out_of_range;
   logic [1:0]          o_sample_rate_select;
   logic                o_sample_tick;
   logic                o_alarm_n;
   logic                o_irq;
   int                  n_mismatch = 0;
   int                  comparisons = 0;
   mac_row_t            rows [7] = '{
      '{ADDR_CONV_CFG, 32'hffff_ffff, 32'h03f8, 1'b0},
      '{ADDR_CONV_CFG, 32'h0, 32'h0, 1'b0},
      '{ADDR_ALARM_ENABLE_CONTROL, 32'hffff_ffff, 32'h7ffc, 1'b0},
      '{ADDR_ALARM_ENABLE_CONTROL, 32'h0, 32'h0, 1'b0},
      '{ADDR_OUT_CFG,  32'hffff_ffff, 32'h0200, 1'b0},
      '{ADDR_IRQ_MASK, 32'hffff_ffff, 32'h7ff8, 1'b0},
      '{12'h3fc,       32'hffff_ffff, 32'h0, 1'b1}};

   mac_top i_mac_top (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(1'b1),
      .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
      .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .i_sample_valid(i_sample_valid),
      .i_out_of_range(i_out_of_range), .o_sample_rate_select(o_sample_rate_select),
      .o_sample_tick(o_sample_tick), .o_alarm_n(o_alarm_n), .o_irq(o_irq));

   always #5 i_ref_clk = ~i_ref_clk;

   // =========================================================
   // tasks
   // =========================================================
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int t;
      t = 0;
      @(posedge i_ref_clk);
      i_psel   <= 1'b1;
      i_pwrite <= w;
      i_paddr  <= a;
      i_pwdata <= d;
      @(posedge i_ref_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         t++;
      end while (o_pready !== 1'b1 && t < 50);
      r = o_prdata;
      e = o_pslverr;
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
      if (t >= 50) n_mismatch++;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask
   task automatic smp(input int j, input logic bad, input int n);
      repeat (n) begin
         @(posedge i_ref_clk);
         i_sample_valid <= 12'h1 << j;
         i_out_of_range <= bad ? (12'h1 << j) : 12'h0;
      end
      @(posedge i_ref_clk);
      i_sample_valid <= 12'h0;
      i_out_of_range <= 12'hfff;
      repeat (3) @(posedge i_ref_clk);
   endtask
   task print_verdict;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      #500_000;
      n_mismatch++;
      print_verdict;
   end

   // =========================================================
   // main sequence
   // =========================================================
   initial begin
      logic [31:0] r;
      logic        e;
      int          j;
      int          n;
      int          k;
      i_ref_clk = 1'b0;
      i_rst_n = 1'b0;
      i_psel = 1'b0;
      i_penable = 1'b0;
      i_pwrite = 1'b0;
      i_paddr = '0;
      i_pwdata = '0;
      i_sample_valid = 12'h000;
      i_out_of_range = 12'hfff;
      repeat (12) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      rd(ADDR_CONV_CFG, r);
      chk("conv reset", r, 32'h0070);
      rd(ADDR_ALARM_ENABLE_CONTROL, r);
      chk("alr reset", r, 32'h0);
      for (k = 0; k < 7; k++) begin
         apb(1'b1, rows[k].addr, rows[k].wdata, r, e);
         chk("wr err", 32'(e), 32'(rows[k].err));
         apb(1'b0, rows[k].addr, 32'h0, r, e);
         chk("rd err", 32'(e), 32'(rows[k].err));
         chk("rd data", r, rows[k].rdata);
      end
      for (k = 0; k < 4; k++) begin
         wr(ADDR_CONV_CFG, 32'(k) << 8);
         repeat ((400 << k) + 10) @(posedge i_ref_clk);
         chk("rate", 32'(o_sample_rate_select), 32'(k));
      end
      for (k = 0; k < 12; k++) begin
         j = (k < 8) ? 11 : 7;
         n = (k < 8) ? ((k == 0) ? 1 : (2 << k)) : (1 << (k - 8));
         wr(ADDR_CONV_CFG, (k < 8) ? (32'(k) << 5) : (32'(k - 8) << 3));
         smp(j, 1'b1, n - 1);
         smp(j, 1'b0, 1);
         smp(j, 1'b1, n - 1);
         rd(ADDR_STATUS, r);
         chk("run short", r, 32'h0);
         smp(j, 1'b1, 1);
         rd(ADDR_STATUS, r);
         chk("run full", r, 32'h1 << (j + 3));
         smp(j, 1'b0, 1);
         rd(ADDR_STATUS, r);
      end
      wr(ADDR_CONV_CFG, 32'h0);
      for (j = 0; j < 12; j++) begin
         wr(ADDR_ALARM_ENABLE_CONTROL, 32'h0);
         smp(j, 1'b1, 1);
         rd(ADDR_STATUS, r);
         chk("masked flag", r, 32'h1 << (j + 3));
         chk("masked pin", 32'(o_alarm_n), 32'h1);
         smp(j, 1'b0, 1);
         rd(ADDR_STATUS, r);
         wr(ADDR_ALARM_ENABLE_CONTROL, 32'h1 << (j + 3));
         smp(j, 1'b1, 1);
         chk("on pin", 32'(o_alarm_n), 32'h0);
         chk("irq", 32'(o_irq), 32'h1);
         smp(j, 1'b0, 1);
         rd(ADDR_STATUS, r);
         wr(ADDR_IRQ_STAT, 32'h7ff8);
         repeat (2) @(posedge i_ref_clk);
         chk("pin off", 32'(o_alarm_n), 32'h1);
         chk("irq off", 32'(o_irq), 32'h0);
      end
      wr(ADDR_OUT_CFG, 32'h0);
      wr(ADDR_ALARM_ENABLE_CONTROL, 32'h4000);
      smp(11, 1'b1, 1);
      chk("pin gated", 32'(o_alarm_n), 32'h1);
      rd(ADDR_OUT_CFG, r);
      chk("global set", r, 32'h0040);
      wr(ADDR_OUT_CFG, 32'h0200);
      repeat (2) @(posedge i_ref_clk);
      chk("pin driven", 32'(o_alarm_n), 32'h0);
      rd(ADDR_STATUS, r);
      chk("held live", r, 32'h4000);
      smp(11, 1'b0, 1);
      chk("held pin", 32'(o_alarm_n), 32'h0);
      rd(ADDR_STATUS, r);
      rd(ADDR_STATUS, r);
      chk("held gone", r, 32'h0);
      rd(ADDR_OUT_CFG, r);
      chk("global gone", r, 32'h0200);
      wr(ADDR_ALARM_ENABLE_CONTROL, 32'h4004);
      wr(ADDR_IRQ_STAT, 32'h7ff8);
      wr(ADDR_IRQ_MASK, 32'h0);
      smp(11, 1'b1, 1);
      chk("irq masked", 32'(o_irq), 32'h0);
      wr(ADDR_IRQ_MASK, 32'h4000);
      repeat (2) @(posedge i_ref_clk);
      chk("irq raised", 32'(o_irq), 32'h1);
      wr(ADDR_IRQ_STAT, 32'h4000);
      repeat (2) @(posedge i_ref_clk);
      chk("irq cleared", 32'(o_irq), 32'h0);
      smp(11, 1'b0, 1);
      chk("live pin", 32'(o_alarm_n), 32'h1);
      rd(ADDR_STATUS, r);
      chk("live flag", r, 32'h0);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      rd(ADDR_CONV_CFG, r);
      chk("conv rereset", r, 32'h0070);
      rd(ADDR_ALARM_ENABLE_CONTROL, r);
      chk("alr rereset", r, 32'h0);
      print_verdict;
   end
endmodule
